/* File: hdl/lli_top.sv */
// Top of the LED latch indicator logic with register port
`timescale 1ns/10ps
module lli_top
    import lli_pkg::*;
(
    input wire logic clock, // System clock, 20 MHz
    input wire logic rst, // Async reset, active high
    input wire lli_pkg::lli_bus_t bus, // Register port request
    output logic [31:0] rdata, // Read data, cycle after read
    input wire logic [LLI_NUM_SRC-1:0] src, // Trigger signal pool
    input wire logic panel_key, // Panel acknowledge key pulse
    input wire logic group_indicator_ack, // Group acknowledge signal
    input wire logic scada_ack, // SCADA acknowledge pulse
    input wire logic prot_alarm, // Any protection alarm
    input wire logic prot_active, // Protection active
    output lli_pkg::lli_lamp_t [LLI_NUM_LEDS-1:0] lamps, // LED drives
    output lli_pkg::lli_lamp_t sys_ok_lamp, // System-OK lamp
    output logic supervision_contact // Energised when healthy
);
    import lli_pkg::*;

    // --------------------------------------------------------------
    // Configuration storage
    // --------------------------------------------------------------
    // Config lives in retained storage: only rst initialises it, a
    // firmware restart without rst keeps latched states
    lli_cfg_t cfg_r [LLI_NUM_LEDS];
    logic [LLI_NUM_TRIG*LLI_SEL_W-1:0] sel_r [LLI_NUM_LEDS];
    logic [2:0] ctrl_r;
    logic [31:0] rdata_nxt;
    logic [LLI_NUM_LEDS-1:0] state;
    logic [LLI_FLASH_W-1:0] flash_cnt_r;
    logic flash_r;
    logic remote_ok;
    logic group_clr;
    lli_sys_t sys_r;
    lli_lamp_t sys_lamp_nxt;
    lli_lamp_t [LLI_NUM_LEDS-1:0] lamp_w;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        hit = (a >= base) && (d[7:2] < 6'(LLI_NUM_LEDS)) && (d[1:0] == 2'h0);
    endfunction : hit

    // Word slot inside a per-indicator bank; meaningful only on a hit
    function automatic logic [2:0] slot(input logic [7:0] a,
                                        input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        slot = d[4:2];
    endfunction : slot

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= LLI_CTRL_RST;
            for (int i = 0; i < LLI_NUM_LEDS; i++) begin
                cfg_r[i] <= '0;
                sel_r[i] <= '0;
            end
        end else if (bus.wr) begin
            if (bus.addr == LLI_OFS_CTRL) begin
                ctrl_r <= bus.wdata[2:0];
            end
            if (hit(bus.addr, LLI_OFS_LED0)) begin
                cfg_r[slot(bus.addr, LLI_OFS_LED0)] <=
                    lli_cfg_t'(bus.wdata[$bits(lli_cfg_t)-1:0]);
            end
            if (hit(bus.addr, LLI_OFS_SEL0)) begin
                sel_r[slot(bus.addr, LLI_OFS_SEL0)] <=
                    bus.wdata[LLI_NUM_TRIG*LLI_SEL_W-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // Register read
    // --------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0;
        if (bus.addr == LLI_OFS_CTRL) begin
            rdata_nxt = {29'h0, ctrl_r};
        end else if (bus.addr == LLI_OFS_STAT) begin
            rdata_nxt = {24'h0, state};
        end else if (hit(bus.addr, LLI_OFS_LED0)) begin
            rdata_nxt = 32'(cfg_r[slot(bus.addr, LLI_OFS_LED0)]);
        end else if (hit(bus.addr, LLI_OFS_SEL0)) begin
            rdata_nxt = 32'(sel_r[slot(bus.addr, LLI_OFS_SEL0)]);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0;
        end else if (bus.rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 32'h0;
        end
    end

    // --------------------------------------------------------------
    // Flash timebase and acknowledge fan-out
    // --------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flash_cnt_r <= '0;
            flash_r <= 1'b0;
        end else if (flash_cnt_r == LLI_FLASH_W'(LLI_FLASH_CYC - 1)) begin
            flash_cnt_r <= '0;
            flash_r <= ~flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 1'b1;
        end
    end

    assign remote_ok = ctrl_r[LLI_CTRL_REMOTE];
    // Remote sources gated, panel key always effective
    assign group_clr = panel_key
                       || (remote_ok && group_indicator_ack)
                       || (remote_ok && scada_ack);

    for (genvar g = 0; g < LLI_NUM_LEDS; g++) begin : g_led
        lli_indicator u_ind (
            .clock(clock),
            .rst(rst),
            .src(src),
            .sel(sel_r[g]),
            .cfg(cfg_r[g]),
            .group_clr(group_clr),
            .alarm_clr(prot_alarm),
            .flash(flash_r),
            .state(state[g]),
            .lamp(lamp_w[g])
        );
    end

    assign lamps = lamp_w;

    // --------------------------------------------------------------
    // System health
    // --------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_r <= LLI_SYS_BOOT;
        end else begin
            unique case (sys_r)
                LLI_SYS_BOOT: begin
                    if (ctrl_r[LLI_CTRL_BOOTED] && prot_active) begin
                        sys_r <= LLI_SYS_RUN;
                    end
                end
                LLI_SYS_RUN: begin
                    if (ctrl_r[LLI_CTRL_FAULT] || !prot_active) begin
                        sys_r <= LLI_SYS_FAULT;
                    end
                end
                LLI_SYS_FAULT: begin
                    if (!ctrl_r[LLI_CTRL_FAULT] && prot_active) begin
                        sys_r <= LLI_SYS_RUN;
                    end
                end
                default: sys_r <= LLI_SYS_BOOT;
            endcase
        end
    end

    always_comb begin
        sys_lamp_nxt = '0;
        if (sys_r == LLI_SYS_BOOT) begin
            sys_lamp_nxt.green = flash_r;
        end else if (sys_r == LLI_SYS_RUN) begin
            sys_lamp_nxt.green = 1'b1;
        end else begin
            sys_lamp_nxt.red = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_ok_lamp <= '0;
            supervision_contact <= 1'b0;
        end else begin
            sys_ok_lamp <= sys_lamp_nxt;
            // Dropped-off through boot and on any fault
            supervision_contact <= (sys_r == LLI_SYS_RUN)
                                   && !ctrl_r[LLI_CTRL_FAULT] && prot_active;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    AST_CONTACT_BOOT_OFF: assert property (@(posedge clock) disable iff (rst)
        sys_r == LLI_SYS_BOOT |=> !supervision_contact)
        else $error("Supervision contact energised during boot");
    AST_CONTACT_FAULT_OFF: assert property (@(posedge clock) disable iff (rst)
        ctrl_r[LLI_CTRL_FAULT] |=> !supervision_contact)
        else $error("Supervision contact energised with fault");
    AST_SYSOK_STEADY: assert property (@(posedge clock) disable iff (rst)
        sys_r == LLI_SYS_RUN |=> sys_ok_lamp.green)
        else $error("System-OK lamp not steady green");
    AST_REMOTE_GATED: assert property (@(posedge clock) disable iff (rst)
        !remote_ok && !panel_key |-> !group_clr)
        else $error("Remote acknowledge passed while disabled");
    AST_FLASH_TOGGLE: assert property (@(posedge clock) disable iff (rst)
        flash_cnt_r == LLI_FLASH_W'(LLI_FLASH_CYC - 1) |=> $changed(flash_r))
        else $error("Flash phase did not toggle");
    AST_READ_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
        !bus.rd |=> rdata == 32'h0)
        else $error("Read data outside read answer cycle");
    COV_BOOT_TO_RUN: cover property (@(posedge clock) disable iff (rst)
        sys_r == LLI_SYS_BOOT ##1 sys_r == LLI_SYS_RUN);
    COV_GROUP_ACK: cover property (@(posedge clock) disable iff (rst)
        remote_ok && group_indicator_ack);
    COV_ALARM: cover property (@(posedge clock) disable iff (rst)
        prot_alarm && |state);
endmodule : lli_top

/* File: hdl/lli_pkg.sv */
// Package with constants and types for the LED latch indicator logic
// Summary of operation
// - Up to five triggers ORed per indicator
// - Per-trigger inversion before combining
// - Unassigned slot always contributes zero
// - Unlatched indicator mirrors combined triggers
// - Latched indicator holds until acknowledged
// - Clear only after all triggers dropped
// - Per-indicator acknowledge clears latched state
// - Latch-off or no assignment clears state
// - Latched state survives restart without rst; rst clears it
// - Active colour shown when any trigger active
// - Inactive colour shown when none active and not latched
// - Group acknowledge clears every latched indicator
// - SCADA acknowledge clears all latched indicators
// - Remote acknowledges need remote reset enable
// - Alarm-ack mode cleared by protection alarm
// - System-OK flashes green booting, then steady
// - Supervision contact energises only when healthy
package lli_pkg;

    localparam int LLI_NUM_LEDS = 8;
    localparam int LLI_NUM_TRIG = 5;
    localparam int LLI_NUM_SRC = 32;
    localparam int LLI_SEL_W = 6;

    // Flash timing
    localparam int LLI_CLK_HZ = 20000000;
    localparam int LLI_FLASH_HALF_MS = 250;
    localparam int LLI_FLASH_CYC = LLI_CLK_HZ / 1000 * LLI_FLASH_HALF_MS;
    localparam int LLI_FLASH_W = 24;

    // Register map: config words are at index*4 from LLI_OFS_LED0
    localparam logic [7:0] LLI_OFS_CTRL = 8'h00;
    localparam logic [7:0] LLI_OFS_STAT = 8'h04;
    localparam logic [7:0] LLI_OFS_LED0 = 8'h10;
    localparam logic [7:0] LLI_OFS_SEL0 = 8'h40;

    // Control register fields
    localparam int LLI_CTRL_REMOTE = 0;
    localparam int LLI_CTRL_BOOTED = 1;
    localparam int LLI_CTRL_FAULT = 2;
    localparam logic [2:0] LLI_CTRL_RST = 3'h0;

    // Per-indicator config word fields
    localparam int LLI_CFG_INV = 0;
    localparam int LLI_CFG_LMODE = 5;
    localparam int LLI_CFG_ACOL = 8;
    localparam int LLI_CFG_ICOL = 11;
    localparam int LLI_CFG_ACK = 16;

    // Selector code 0 means unassigned; code n picks source n-1
    localparam logic [LLI_SEL_W-1:0] LLI_SEL_NONE = 6'h00;

    typedef enum logic [1:0] {
        LLI_LATCH_OFF,
        LLI_LATCH_ON,
        LLI_LATCH_ALARM
    } lli_lmode_t;

    typedef enum logic [2:0] {
        LLI_COL_NONE,
        LLI_COL_GREEN,
        LLI_COL_RED,
        LLI_COL_RED_FLASH,
        LLI_COL_GREEN_FLASH
    } lli_colour_t;

    typedef struct packed {
        logic [LLI_SEL_W-1:0] ack_sel;
        lli_colour_t inact_col;
        lli_colour_t act_col;
        lli_lmode_t lmode;
        logic [LLI_NUM_TRIG-1:0] invert;
    } lli_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lli_bus_t;

    typedef struct packed {
        logic green;
        logic red;
    } lli_lamp_t;

    typedef enum logic [1:0] {
        LLI_SYS_BOOT,
        LLI_SYS_RUN,
        LLI_SYS_FAULT
    } lli_sys_t;

endpackage : lli_pkg

/* File: hdl/lli_indicator.sv */
// One configurable indicator: trigger combine, latch and colour
`timescale 1ns/10ps
module lli_indicator
    import lli_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [LLI_NUM_SRC-1:0] src, // Signal pool
    input wire logic [LLI_NUM_TRIG*LLI_SEL_W-1:0] sel, // Trigger selectors
    input wire lli_pkg::lli_cfg_t cfg, // Indicator config
    input wire logic group_clr, // Clear request for all
    input wire logic alarm_clr, // Protection alarm clear
    input wire logic flash, // Flash phase
    output logic state, // Indicator state
    output lli_pkg::lli_lamp_t lamp // Lamp drive, registered
);
    logic [LLI_NUM_TRIG-1:0] trig;
    logic any_assigned;
    logic comb;
    logic ack_hit;
    logic clr_req;
    logic latch_r;

    function automatic logic pick(input logic [LLI_NUM_SRC-1:0] pool,
                                  input logic [LLI_SEL_W-1:0] code);
        logic [LLI_SEL_W-1:0] idx;
        idx = code - 6'h01;
        if (code == LLI_SEL_NONE || code > 6'(LLI_NUM_SRC)) begin
            pick = 1'b0;
        end else begin
            pick = pool[idx[4:0]];
        end
    endfunction : pick

    function automatic lli_lamp_t paint(input lli_colour_t c,
                                        input logic ph);
        paint = '0;
        unique case (c)
            LLI_COL_NONE: paint = '0;
            LLI_COL_GREEN: paint.green = 1'b1;
            LLI_COL_RED: paint.red = 1'b1;
            LLI_COL_RED_FLASH: paint.red = ph;
            LLI_COL_GREEN_FLASH: paint.green = ph;
            default: paint = '0;
        endcase
    endfunction : paint

    always_comb begin
        any_assigned = 1'b0;
        for (int i = 0; i < LLI_NUM_TRIG; i++) begin
            if (sel[i*LLI_SEL_W +: LLI_SEL_W] == LLI_SEL_NONE) begin
                trig[i] = 1'b0;
            end else begin
                any_assigned = 1'b1;
                // Invert only assigned slots
                trig[i] = pick(src, sel[i*LLI_SEL_W +: LLI_SEL_W])
                          ^ cfg.invert[i];
            end
        end
        comb = |trig;
    end

    assign ack_hit = pick(src, cfg.ack_sel);
    assign clr_req = ack_hit || group_clr
                     || (alarm_clr && cfg.lmode == LLI_LATCH_ALARM);

    // Latch; no clear while triggers still active
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            latch_r <= 1'b0;
        end else if (cfg.lmode == LLI_LATCH_OFF || !any_assigned) begin
            latch_r <= 1'b0;
        end else if (comb) begin
            latch_r <= 1'b1;
        end else if (clr_req) begin
            latch_r <= 1'b0;
        end
    end

    // Unlatched mirrors triggers directly
    assign state = (cfg.lmode == LLI_LATCH_OFF) ? comb : (comb | latch_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lamp <= '0;
        end else if (state) begin
            lamp <= paint(cfg.act_col, flash);
        end else begin
            lamp <= paint(cfg.inact_col, flash);
        end
    end

    AST_UNLATCHED_MIRROR: assert property (@(posedge clock) disable iff (rst)
        cfg.lmode == LLI_LATCH_OFF |-> state == comb)
        else $error("Unlatched indicator differs from triggers");
    AST_HOLD_WHILE_ACTIVE: assert property (@(posedge clock) disable iff (rst)
        (latch_r && comb && cfg.lmode != LLI_LATCH_OFF
         && $stable(cfg.lmode)) |=> latch_r)
        else $error("Latch cleared while trigger active");
    AST_UNASSIGNED_ZERO: assert property (@(posedge clock) disable iff (rst)
        !any_assigned |-> !comb)
        else $error("Unassigned slots produced activity");
    AST_ACK_CLEARS: assert property (@(posedge clock) disable iff (rst)
        (cfg.lmode != LLI_LATCH_OFF && !comb && ack_hit) |=> !latch_r)
        else $error("Per-indicator acknowledge ignored");
    AST_LATCH_KEEPS: assert property (@(posedge clock) disable iff (rst)
        (latch_r && !clr_req && cfg.lmode != LLI_LATCH_OFF && any_assigned)
        |=> latch_r)
        else $error("Latched state lost without acknowledge");
    AST_ACTIVE_COLOUR: assert property (@(posedge clock) disable iff (rst)
        (state && cfg.act_col == LLI_COL_RED) |=> lamp.red && !lamp.green)
        else $error("Active colour not shown");
    COV_LATCH_HOLD: cover property (@(posedge clock) disable iff (rst)
        latch_r && !comb ##1 latch_r);
endmodule : lli_indicator

/* File: bench/lli_far_side.sv */
// Far-side model: trigger pool, panel key, remote and alarm sources
`timescale 1ns/10ps
module lli_far_side (
    input wire logic clock, // System clock
    output logic [31:0] src, // Trigger pool
    output logic panel_key, // Panel key pulse
    output logic group_indicator_ack, // Group acknowledge
    output logic scada_ack, // SCADA acknowledge
    output logic prot_alarm, // Protection alarm
    output logic prot_active // Protection active
);
    initial begin
        src = 32'h0;
        {panel_key, group_indicator_ack, scada_ack, prot_alarm} = 4'h0;
        prot_active = 1'b0;
    end

    task automatic set_src(input logic [31:0] v);
        @(posedge clock);
        src <= v;
    endtask : set_src

    // One-cycle pulse: 0 panel, 1 group, 2 SCADA, else alarm
    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: panel_key <= 1'b1;
            1: group_indicator_ack <= 1'b1;
            2: scada_ack <= 1'b1;
            default: prot_alarm <= 1'b1;
        endcase
        @(posedge clock);
        {panel_key, group_indicator_ack, scada_ack, prot_alarm} <= 4'h0;
    endtask : pulse

    task automatic set_active(input logic v);
        @(posedge clock);
        prot_active <= v;
    endtask : set_active
endmodule : lli_far_side

/* File: bench/tb_top.sv */
// Self-checking bench for the LED latch indicator logic
`timescale 1ns/10ps
module tb_top;
    import lli_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    lli_bus_t bus = '0;
    logic [31:0] rdata;
    logic [31:0] src;
    logic panel_key, group_indicator_ack, scada_ack, prot_alarm, prot_active;
    lli_lamp_t [LLI_NUM_LEDS-1:0] lamps;
    lli_lamp_t sys_ok_lamp;
    logic supervision_contact;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    logic rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h41fc;
    logic [31:0] v;
    logic [4:0] inv;
    logic e0, e1;

    always #25 clock = ~clock;

    lli_top u_lli_top (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .src(src), .panel_key(panel_key),
        .group_indicator_ack(group_indicator_ack), .scada_ack(scada_ack),
        .prot_alarm(prot_alarm), .prot_active(prot_active), .lamps(lamps),
        .sys_ok_lamp(sys_ok_lamp), .supervision_contact(supervision_contact));
    lli_far_side u_lli_far_side (.clock(clock), .src(src),
        .panel_key(panel_key),
        .group_indicator_ack(group_indicator_ack), .scada_ack(scada_ack),
        .prot_alarm(prot_alarm), .prot_active(prot_active));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] cfg(input logic [1:0] m,
        input logic [2:0] ac, input logic [2:0] ic, input logic [4:0] iv,
        input logic [5:0] ak);
        return {13'h0, ak, ic, ac, m, iv};
    endfunction : cfg

    task automatic tally_and_finish();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        compare({24'h0, got}, {24'h0, exp});
    endtask : chk_pin

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clock);
        bus <= '0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle

    // Random noise on pool bits that no selector uses here
    function automatic logic [31:0] nz(input logic [31:0] x);
        return x | (xs() & 32'hffff_ff80);
    endfunction : nz

    // Raise then drop the LED1 trigger (src5)
    task automatic latch_set();
        u_lli_far_side.set_src(nz(32'h20));
        idle(3);
        u_lli_far_side.set_src(nz(32'h0));
        idle(3);
    endtask : latch_set

    // Read answers stand only in the cycle after the strobe
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                compare(rdata, 32'hdead_beef);
            end else begin
                compare(rdata, exp_q.pop_front());
            end
        end
        rd_d <= bus.rd;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        idle(2);
        chk_pin({supervision_contact, sys_ok_lamp.red}, 8'h0);
        rd(LLI_OFS_CTRL, 32'h0);
        rd(LLI_OFS_LED0, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, 32'h0);
        v = xs() & 32'h3fff_ffff;
        wr(LLI_OFS_SEL0 + 8'h1c, v);
        rd(LLI_OFS_SEL0 + 8'h1c, v);
        wr(LLI_OFS_SEL0 + 8'h1c, 32'h0);
        wr(LLI_OFS_STAT, 32'hff);
        rd(LLI_OFS_STAT, 32'h0);
        // Combine and invert: LED0 all slots, LED1 slot2 only
        wr(LLI_OFS_SEL0, {2'h0, 6'd5, 6'd4, 6'd3, 6'd2, 6'd1});
        wr(LLI_OFS_SEL0 + 8'h4, {14'h0, 6'd3, 12'h0});
        wr(LLI_OFS_LED0 + 8'h4, cfg(2'h0, LLI_COL_NONE, LLI_COL_GREEN,
            5'h1f, 6'h0));
        for (int k = 0; k < 10; k++) begin
            v = xs();
            inv = v[12:8];
            wr(LLI_OFS_LED0, cfg(2'h0, LLI_COL_GREEN, LLI_COL_RED, inv, 6'h0));
            v = xs();
            u_lli_far_side.set_src(v);
            idle(3);
            e0 = |(v[4:0] ^ inv);
            e1 = ~v[2];
            rd(LLI_OFS_STAT, {30'h0, e1, e0});
            chk_pin({lamps[1], lamps[0]}, {4'h0, e1 ? 2'b00 : 2'b10,
                e0 ? 2'b10 : 2'b01});
        end
        // Latching on LED1: trigger src5, own acknowledge src6
        wr(LLI_OFS_LED0, 32'h0);
        u_lli_far_side.set_src(nz(32'h0));
        wr(LLI_OFS_SEL0 + 8'h4, 32'd6);
        wr(LLI_OFS_LED0 + 8'h4, cfg(2'h1, LLI_COL_RED, LLI_COL_NONE,
            5'h0, 6'd7));
        latch_set();
        rd(LLI_OFS_STAT, 32'h2);
        chk_pin(lamps[1], 8'h1);
        u_lli_far_side.set_src(nz(32'h60));
        idle(3);
        u_lli_far_side.set_src(nz(32'h0));
        idle(3);
        rd(LLI_OFS_STAT, 32'h2);
        u_lli_far_side.set_src(nz(32'h40));
        u_lli_far_side.set_src(nz(32'h0));
        idle(3);
        rd(LLI_OFS_STAT, 32'h0);
        // Panel key, lost while the trigger stands
        latch_set();
        u_lli_far_side.set_src(nz(32'h20));
        u_lli_far_side.pulse(0);
        u_lli_far_side.set_src(nz(32'h0));
        idle(3);
        rd(LLI_OFS_STAT, 32'h2);
        u_lli_far_side.pulse(0);
        idle(3);
        rd(LLI_OFS_STAT, 32'h0);
        // Remote acknowledges, first without enable
        latch_set();
        for (int w = 1; w < 3; w++) begin
            u_lli_far_side.pulse(w);
        end
        idle(3);
        rd(LLI_OFS_STAT, 32'h2);
        wr(LLI_OFS_CTRL, 32'h1);
        rd(LLI_OFS_CTRL, 32'h1);
        // Group acknowledge first, then SCADA
        for (int w = 1; w < 3; w++) begin
            latch_set();
            u_lli_far_side.pulse(w);
            idle(3);
            rd(LLI_OFS_STAT, 32'h0);
            chk_pin(lamps[1], 8'h0);
        end
        // Alarm clears only in the alarm-acknowledge mode
        for (int m = 1; m < 3; m++) begin
            if (m == 2) begin
                wr(LLI_OFS_LED0 + 8'h4, cfg(2'h0, LLI_COL_RED, LLI_COL_NONE,
                    5'h0, 6'd7));
                idle(3);
                rd(LLI_OFS_STAT, 32'h0);
                wr(LLI_OFS_LED0 + 8'h4, cfg(2'h2, LLI_COL_RED, LLI_COL_NONE,
                    5'h0, 6'd7));
                rd(LLI_OFS_STAT, 32'h0);
            end
            latch_set();
            u_lli_far_side.pulse(3);
            idle(3);
            rd(LLI_OFS_STAT, (m == 1) ? 32'h2 : 32'h0);
            chk_pin(lamps[1], (m == 1) ? 8'h1 : 8'h0);
        end
        latch_set();
        wr(LLI_OFS_SEL0 + 8'h4, 32'h0);
        idle(3);
        rd(LLI_OFS_STAT, 32'h0);
        // System-OK lamp and supervision contact
        wr(LLI_OFS_CTRL, 32'h3);
        u_lli_far_side.set_active(1'b1);
        idle(4);
        chk_pin({supervision_contact, sys_ok_lamp}, 8'h6);
        wr(LLI_OFS_CTRL, 32'h7);
        idle(4);
        chk_pin({supervision_contact, sys_ok_lamp}, 8'h1);
        wr(LLI_OFS_CTRL, 32'h3);
        u_lli_far_side.set_active(1'b0);
        idle(4);
        chk_pin(supervision_contact, 8'h0);
        idle(3);
        tally_and_finish();
    end
endmodule : tb_top
